// *** hdl/sac_pkg.sv ***
// constants, register map and state types of the serial converter port
package sac_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NAP_WAKE_NS = 350;
  // longest time: round down
  localparam int NAP_WAKE_CYC = NAP_WAKE_NS / CLK_PERIOD_NS;
  localparam int REF_SETTLE_US = 4000;
  localparam int REF_SETTLE_CYC = REF_SETTLE_US * 1000 / CLK_PERIOD_NS;
  // least start-to-clock spacing; least time: round up
  localparam int START_GAP_NS = 50;
  localparam int START_GAP_CYC = (START_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // result format
  // ****************************************
  localparam int CODE_W = 12;
  localparam int WORD_W = CODE_W + 1;
  localparam int SAMPLE_W = 14;
  localparam logic signed [SAMPLE_W-1:0] UNI_MAX = 14'sh0FFF;
  localparam logic signed [SAMPLE_W-1:0] BIP_MAX = 14'sh07FF;
  localparam logic signed [SAMPLE_W-1:0] BIP_MIN = -14'sh0800;
  localparam logic [2:0] NAP_PULSES = 3'h2;
  localparam logic [2:0] SLEEP_PULSES = 3'h4;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_RESET = 1'h1;
  localparam int INT_W = 4;
  localparam int INT_DONE = 0;
  localparam int INT_NAP = 1;
  localparam int INT_SLEEP = 2;
  localparam int INT_REF_OK = 3;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 4'h0;

  typedef enum logic [1:0] {
    SAC_PWR_ACTIVE = 2'b00,
    SAC_PWR_NAP = 2'b01,
    SAC_PWR_SLEEP = 2'b10,
    SAC_PWR_WAKE = 2'b11
  } sac_pwr_t;

  typedef enum logic [1:0] {
    SAC_CV_IDLE = 2'b00,
    SAC_CV_WAIT = 2'b01,
    SAC_CV_SHIFT = 2'b10
  } sac_cv_t;
endpackage : sac_pkg

// *** hdl/sac_edge.sv ***
// rising and falling edge finder for synchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module sac_edge #(
  parameter int N = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels and their edges
  input wire logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  logic [N-1:0] prev_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_reg <= '0;
    else
      prev_reg <= level;
  end

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_edge
      assign rise[i] = level[i] & ~prev_reg[i];
      assign fall[i] = ~level[i] & prev_reg[i];
    end
  endgenerate
endmodule : sac_edge
`default_nettype wire

// *** hdl/sac_shift.sv ***
// output word shifter, msb first, one bit per step
`timescale 1ns/1ps
`default_nettype none
module sac_shift (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic step,
  input wire logic [sac_pkg::WORD_W-1:0] word,
  // output
  output logic dout,
  output logic last
);
  logic [sac_pkg::WORD_W-1:0] sh_reg;
  logic [3:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_reg <= '0;
      cnt_reg <= 4'h0;
    end
    else if (load)
    begin
      sh_reg <= word;
      cnt_reg <= 4'h1;
    end
    else if (step)
    begin
      sh_reg <= {sh_reg[sac_pkg::WORD_W-2:0], 1'b0};
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  assign dout = sh_reg[sac_pkg::WORD_W-1];
  assign last = (cnt_reg == 4'(sac_pkg::WORD_W));
endmodule : sac_shift
`default_nettype wire

// *** hdl/sac_conversion_port.sv ***
// control and serial output of a 12-bit sampling converter, with ahb-lite registers
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sac_conversion_port #(
  parameter int REF_SETTLE_CYC = sac_pkg::REF_SETTLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial link pins
  input wire logic sclk,
  input wire logic conversion_start,
  output logic dout,
  // analog front end
  input wire logic signed [sac_pkg::SAMPLE_W-1:0] sample_mv,
  input wire logic vss_below_gnd,
  input wire logic vref_low,
  // interrupt
  output logic irq
);
  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************
  // pin edges
  // ****************************************
  logic [1:0] pin_rise;
  logic sclk_rise;
  logic start_rise;

  sac_edge #(.N(2)) u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .level({conversion_start, sclk}),
    .rise(pin_rise),
    .fall()
  );
  assign sclk_rise = pin_rise[0];
  assign start_rise = pin_rise[1];

  function automatic logic [sac_pkg::CODE_W-1:0] code_of(
    input logic signed [sac_pkg::SAMPLE_W-1:0] mv,
    input logic bip
  );
    logic signed [sac_pkg::SAMPLE_W-1:0] c;
    c = mv;
    if (bip)
    begin
      if (mv > sac_pkg::BIP_MAX)
        c = sac_pkg::BIP_MAX;
      else if (mv < sac_pkg::BIP_MIN)
        c = sac_pkg::BIP_MIN;
    end
    else
    begin
      if (mv > sac_pkg::UNI_MAX)
        c = sac_pkg::UNI_MAX;
      else if (mv < 0)
        c = '0;
    end
    return c[sac_pkg::CODE_W-1:0];
  endfunction : code_of

  // ****************************************
  // registers and state
  // ****************************************
  sac_pkg::sac_pwr_t pwr_reg;
  sac_pkg::sac_cv_t cv_reg;
  logic ctrl_en_reg;
  logic [sac_pkg::INT_W-1:0] int_stat_reg;
  logic [sac_pkg::INT_W-1:0] int_mask_reg;
  logic [sac_pkg::CODE_W-1:0] result_reg;
  logic [sac_pkg::CODE_W-1:0] code_reg;
  logic [2:0] pulse_reg;
  logic [5:0] wake_cnt_reg;
  logic [22:0] settle_cnt_reg;
  logic ref_settled_reg;
  logic ref_settled_prev_reg;
  logic [3:0] gap_cnt_reg;
  logic ref_ready;
  logic sh_load;
  logic sh_step;
  logic sh_last;
  logic cycle_done;
  logic [2:0] pulse_next;
  logic enter_nap;
  logic enter_sleep;
  logic start_ok;

  // low reference pulls the flag down at once
  assign ref_ready = ref_settled_reg & ~vref_low;
  assign start_ok = start_rise & ctrl_en_reg & (pwr_reg == sac_pkg::SAC_PWR_ACTIVE)
    & (cv_reg == sac_pkg::SAC_CV_IDLE);

  // ****************************************
  // power-down pulse counting
  // ****************************************
  // pulses only count while the clock line stays low; any clock rise restarts the count
  always_comb
  begin
    pulse_next = pulse_reg;
    if (sclk_rise)
      pulse_next = 3'h0;
    else if (start_rise && !sclk && cv_reg != sac_pkg::SAC_CV_SHIFT
             && pwr_reg != sac_pkg::SAC_PWR_WAKE && pulse_reg != sac_pkg::SLEEP_PULSES)
      pulse_next = pulse_reg + 3'h1;
  end
  assign enter_nap = (pulse_next == sac_pkg::NAP_PULSES) && (pulse_reg != pulse_next);
  assign enter_sleep = (pulse_next == sac_pkg::SLEEP_PULSES)
    && (pulse_reg != pulse_next);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pulse_reg <= 3'h0;
    else
      pulse_reg <= pulse_next;
  end

  // ****************************************
  // power state
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_reg <= sac_pkg::SAC_PWR_ACTIVE;
      wake_cnt_reg <= 6'h0;
    end
    else
    begin
      case (pwr_reg)
        sac_pkg::SAC_PWR_ACTIVE:
          if (enter_nap)
            pwr_reg <= sac_pkg::SAC_PWR_NAP;
        sac_pkg::SAC_PWR_NAP:
          if (enter_sleep)
            pwr_reg <= sac_pkg::SAC_PWR_SLEEP;
          else if (sclk_rise)
          begin
            pwr_reg <= sac_pkg::SAC_PWR_WAKE;
            wake_cnt_reg <= 6'(sac_pkg::NAP_WAKE_CYC - 1);
          end
        sac_pkg::SAC_PWR_SLEEP:
          if (sclk_rise)
            pwr_reg <= sac_pkg::SAC_PWR_ACTIVE;
        sac_pkg::SAC_PWR_WAKE:
          if (wake_cnt_reg == 6'h0)
            pwr_reg <= sac_pkg::SAC_PWR_ACTIVE;
          else
            wake_cnt_reg <= wake_cnt_reg - 6'h1;
        default:
          pwr_reg <= sac_pkg::SAC_PWR_ACTIVE;
      endcase
    end
  end

  // ****************************************
  // reference settling
  // ****************************************
  // the reference is cut in sleep and only trusted again after the settle time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_settled_reg <= 1'b1;
      settle_cnt_reg <= 23'h0;
    end
    else if (pwr_reg == sac_pkg::SAC_PWR_SLEEP)
    begin
      ref_settled_reg <= 1'b0;
      settle_cnt_reg <= 23'(REF_SETTLE_CYC - 1);
    end
    else if (!ref_settled_reg)
    begin
      if (settle_cnt_reg == 23'h0)
        ref_settled_reg <= 1'b1;
      else
        settle_cnt_reg <= settle_cnt_reg - 23'h1;
    end
  end

  // ****************************************
  // conversion and serial output
  // ****************************************
  assign sh_load = (cv_reg == sac_pkg::SAC_CV_WAIT) && sclk_rise
    && (gap_cnt_reg >= 4'(sac_pkg::START_GAP_CYC));
  assign sh_step = (cv_reg == sac_pkg::SAC_CV_SHIFT) && sclk_rise && !sh_last;
  assign cycle_done = (cv_reg == sac_pkg::SAC_CV_SHIFT) && sclk_rise && sh_last;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cv_reg <= sac_pkg::SAC_CV_IDLE;
      code_reg <= '0;
      gap_cnt_reg <= 4'h0;
    end
    else
    begin
      case (cv_reg)
        sac_pkg::SAC_CV_IDLE:
          if (start_ok)
          begin
            cv_reg <= sac_pkg::SAC_CV_WAIT;
            code_reg <= code_of(sample_mv, vss_below_gnd);
            gap_cnt_reg <= 4'h1;
          end
        sac_pkg::SAC_CV_WAIT:
          if (enter_nap)
            cv_reg <= sac_pkg::SAC_CV_IDLE;
          else if (sh_load)
            cv_reg <= sac_pkg::SAC_CV_SHIFT;
          else if (gap_cnt_reg != 4'hF)
            gap_cnt_reg <= gap_cnt_reg + 4'h1;
        sac_pkg::SAC_CV_SHIFT:
          if (cycle_done)
            cv_reg <= sac_pkg::SAC_CV_IDLE;
        default:
          cv_reg <= sac_pkg::SAC_CV_IDLE;
      endcase
    end
  end

  logic sh_dout;

  sac_shift u_shift (
    .clk(clk),
    .rst_n(rst_n),
    .load(sh_load),
    .step(sh_step),
    .word({ref_ready, code_reg}),
    .dout(sh_dout),
    .last(sh_last)
  );
  assign dout = sh_dout;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      result_reg <= '0;
    else if (cycle_done)
      result_reg <= code_reg;
  end

  // ****************************************
  // ahb-lite slave
  // ****************************************
  logic addr_ok;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic rd_int;

  assign addr_ok = hsel && htrans[1] && hready;
  // aliased addresses read zero, so they must not clear events either
  assign rd_int = addr_ok && !hwrite && (haddr[7:0] == sac_pkg::ADDR_INT_STATUS)
    && haddr[31:8] == 24'h00_0000;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= addr_ok && hwrite && haddr[31:8] == 24'h00_0000;
      wr_addr_reg <= haddr[7:0];
      hrdata <= 32'h0000_0000;
      if (addr_ok && !hwrite && haddr[31:8] == 24'h00_0000)
      begin
        case (haddr[7:0])
          sac_pkg::ADDR_CTRL:
            hrdata <= {31'h0000_0000, ctrl_en_reg};
          sac_pkg::ADDR_STATUS:
            hrdata <= {27'h000_0000, vss_below_gnd, ref_ready,
                       cv_reg != sac_pkg::SAC_CV_IDLE, pwr_reg};
          sac_pkg::ADDR_RESULT:
            hrdata <= {20'h0_0000, result_reg};
          sac_pkg::ADDR_INT_STATUS:
            hrdata <= {28'h000_0000, int_stat_reg};
          sac_pkg::ADDR_INT_MASK:
            hrdata <= {28'h000_0000, int_mask_reg};
          default:
            hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_en_reg <= sac_pkg::CTRL_RESET;
      int_mask_reg <= sac_pkg::INT_MASK_RESET;
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == sac_pkg::ADDR_CTRL)
        ctrl_en_reg <= hwdata[sac_pkg::CTRL_EN_BIT];
      if (wr_addr_reg == sac_pkg::ADDR_INT_MASK)
        int_mask_reg <= hwdata[sac_pkg::INT_W-1:0];
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [sac_pkg::INT_W-1:0] int_set;

  always_comb
  begin
    int_set = '0;
    int_set[sac_pkg::INT_DONE] = cycle_done;
    int_set[sac_pkg::INT_NAP] = enter_nap && pwr_reg == sac_pkg::SAC_PWR_ACTIVE;
    int_set[sac_pkg::INT_SLEEP] = enter_sleep && pwr_reg == sac_pkg::SAC_PWR_NAP;
    int_set[sac_pkg::INT_REF_OK] = ref_settled_reg && !ref_settled_prev_reg;
  end

  // a new event in the clearing read's cycle survives the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_stat_reg <= '0;
      ref_settled_prev_reg <= 1'b1;
    end
    else
    begin
      ref_settled_prev_reg <= ref_settled_reg;
      int_stat_reg <= (rd_int ? '0 : int_stat_reg) | int_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(int_stat_reg & int_mask_reg);
  end

  // ****************************************
  // checks
  // ****************************************
  property p_nap_entry;
    @(posedge clk) disable iff (!rst_n)
    (pwr_reg == sac_pkg::SAC_PWR_ACTIVE && enter_nap) |=> pwr_reg == sac_pkg::SAC_PWR_NAP;
  endproperty
  a_nap_entry: assert property (p_nap_entry) else $error("nap not entered");

  property p_sleep_entry;
    @(posedge clk) disable iff (!rst_n)
    (pwr_reg == sac_pkg::SAC_PWR_NAP && enter_sleep) |=> pwr_reg == sac_pkg::SAC_PWR_SLEEP
      ##1 !ref_ready;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_nap_wake;
    @(posedge clk) disable iff (!rst_n)
    (pwr_reg == sac_pkg::SAC_PWR_NAP && sclk_rise && !enter_sleep)
      |=> ##[1:35] pwr_reg == sac_pkg::SAC_PWR_ACTIVE;
  endproperty
  a_nap_wake: assert property (p_nap_wake) else $error("nap wake too slow");

  property p_sleep_wake;
    @(posedge clk) disable iff (!rst_n)
    (pwr_reg == sac_pkg::SAC_PWR_SLEEP && sclk_rise) |=> pwr_reg == sac_pkg::SAC_PWR_ACTIVE;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake missed");

  property p_ref_low;
    @(posedge clk) disable iff (!rst_n)
    (sh_load && vref_low) |=> !dout;
  endproperty
  a_ref_low: assert property (p_ref_low) else $error("ready flag high with low ref");

  property p_dout_stable;
    @(posedge clk) disable iff (!rst_n)
    !$rose(sclk) |=> $stable(dout);
  endproperty
  a_dout_stable: assert property (p_dout_stable) else $error("dout moved off clock rise");

  property p_flag_first;
    @(posedge clk) disable iff (!rst_n)
    sh_load |=> dout == $past(ref_ready) && cv_reg == sac_pkg::SAC_CV_SHIFT;
  endproperty
  a_flag_first: assert property (p_flag_first) else $error("flag bit not first");

  property p_early_clock;
    @(posedge clk) disable iff (!rst_n)
    (cv_reg == sac_pkg::SAC_CV_WAIT && sclk_rise && gap_cnt_reg < 4'(sac_pkg::START_GAP_CYC))
      |=> cv_reg != sac_pkg::SAC_CV_SHIFT;
  endproperty
  a_early_clock: assert property (p_early_clock) else $error("early clock not skipped");

  property p_no_restart;
    @(posedge clk) disable iff (!rst_n)
    (cv_reg == sac_pkg::SAC_CV_SHIFT && !cycle_done) |=> cv_reg == sac_pkg::SAC_CV_SHIFT;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion cut short");
endmodule : sac_conversion_port
`default_nettype wire

// *** bench/sac_host_model.sv ***
// host side model: serial clock, start line and word capture
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
  // clock
  input wire logic clk,
  // link pins
  input wire logic dout,
  output var logic sclk,
  output var logic conversion_start,
  // captured word
  output var logic [12:0] word,
  output var logic word_v
);
  initial
  begin
    sclk = 1'b0;
    conversion_start = 1'b0;
    word = 13'h0000;
    word_v = 1'b0;
  end

  // sclk stays low here, so the pulses count toward power-down
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk) conversion_start <= 1'b1;
      @(posedge clk) conversion_start <= 1'b0;
    end
  endtask : pulse

  task automatic wake();
    @(posedge clk) sclk <= 1'b1;
    @(posedge clk) sclk <= 1'b0;
  endtask : wake

  // gap: clk cycles from the end of the start pulse to first sclk rise; skip: rises lost to a short gap
  task automatic frame(input int gap, input int skip, input bit extra);
    logic [12:0] w;
    w = 13'h0000;
    pulse(1);
    repeat (gap - 1) @(posedge clk);
    for (int k = 1; k <= 14 + skip; k++)
    begin
      @(posedge clk);
      if (k >= 2 + skip) w = {w[11:0], dout};
      sclk <= 1'b1;
      @(posedge clk);
      @(posedge clk) sclk <= 1'b0;
      conversion_start <= extra && k == 3;
      @(posedge clk) conversion_start <= 1'b0;
    end
    word <= w;
    word_v <= 1'b1;
    @(posedge clk) word_v <= 1'b0;
  endtask : frame
endmodule : sac_host_model
`default_nettype wire

// *** bench/tb_sac_conversion_port.sv ***
// self-checking bench of the serial converter port
`timescale 1ns/1ps
`default_nettype none
module tb_sac_conversion_port;
  localparam int SETTLE = 50;
  logic clk;
  logic nrst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sclk;
  logic conversion_start;
  logic dout;
  logic signed [sac_pkg::SAMPLE_W-1:0] sample_mv;
  logic vss_below_gnd;
  logic vref_low;
  logic irq;
  logic [12:0] word;
  logic word_v;
  logic [31:0] res;
  logic res_v;
  logic [31:0] rd;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int comparisons = 0;
  int seed = 32'hb017;
  int mv;

  sac_conversion_port #(.REF_SETTLE_CYC(SETTLE)) dut_u (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclk(sclk),
    .conversion_start(conversion_start), .dout(dout), .sample_mv(sample_mv),
    .vss_below_gnd(vss_below_gnd), .vref_low(vref_low), .irq(irq)
  );

  sac_host_model host_u (
    .clk(clk), .dout(dout), .sclk(sclk), .conversion_start(conversion_start),
    .word(word), .word_v(word_v)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ********************************
  // result checking
  // ********************************
  task automatic take(input logic [31:0] got);
    logic [31:0] e;
    e = 32'hXXXXXXXX;
    if (exp_q.size() != 0) e = exp_q.pop_front();
    comparisons++;
    if (got !== e)
    begin
      num_errors++;
      $display("unexpected value at %0t ns: got %h, expected %h", $time, got, e);
    end
  endtask : take

  always @(posedge clk)
  begin
    if (word_v === 1'b1) take({19'h00000, word});
    if (res_v === 1'b1) take(res);
  end

  task automatic check(input logic [31:0] e, input logic [31:0] v);
    exp_q.push_back(e);
    @(posedge clk);
    res <= v;
    res_v <= 1'b1;
    @(posedge clk) res_v <= 1'b0;
  endtask : check

  task automatic give_verdict();
    if (exp_q.size() != 0) num_errors++;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // ********************************
  // bus and conversion tasks
  // ********************************
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h00000000);
    check(e, rd);
  endtask : rchk

  // clamp to the coding range, then keep the low twelve bits
  function automatic logic [11:0] code_of(input int v, input logic bip);
    int lo;
    int hi;
    lo = bip ? -2048 : 0;
    hi = bip ? 2047 : 4095;
    if (v < lo) v = lo;
    if (v > hi) v = hi;
    return v[11:0];
  endfunction : code_of

  task automatic convert(input int v, input logic bip, input int gap, input int skip,
                         input bit extra, input logic flag);
    @(posedge clk);
    sample_mv <= v[13:0];
    vss_below_gnd <= bip;
    exp_q.push_back({19'h00000, flag, code_of(v, bip)});
    host_u.frame(gap, skip, extra);
    rchk(sac_pkg::ADDR_RESULT, {20'h00000, code_of(v, bip)});
  endtask : convert

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    sample_mv = 14'sh0000;
    vss_below_gnd = 1'b0;
    vref_low = 1'b0;
    res = 32'h00000000;
    res_v = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(sac_pkg::ADDR_CTRL, 32'h00000001);
    rchk(sac_pkg::ADDR_STATUS, 32'h00000008);
    rchk(sac_pkg::ADDR_INT_MASK, 32'h00000000);
    check(32'h00000000, {31'h00000000, hresp});
    ahb(1'b1, 8'h40, 32'hFFFFFFFF);
    rchk(8'h40, 32'h00000000);
    $display("test done: reset values and map");
    convert(4095, 1'b0, 6, 0, 1'b0, 1'b1);
    check(32'h00000000, {31'h00000000, irq});
    ahb(1'b1, sac_pkg::ADDR_INT_MASK, 32'h00000001);
    repeat (2) @(posedge clk);
    check(32'h00000001, {31'h00000000, irq});
    rchk(sac_pkg::ADDR_INT_STATUS, 32'h00000001);
    repeat (2) @(posedge clk);
    check(32'h00000000, {31'h00000000, irq});
    $display("test done: interrupt");
    convert(2047, 1'b1, 7, 0, 1'b0, 1'b1);
    convert(-2048, 1'b1, 8, 0, 1'b0, 1'b1);
    rchk(sac_pkg::ADDR_STATUS, 32'h00000018);
    for (int i = 0; i < 8; i++)
    begin
      mv = $random(seed) % 5000;
      convert(mv, i[0], 6 + i % 4, 0, 1'b0, 1'b1);
    end
    $display("test done: result coding");
    convert(1234, 1'b0, 2, 1, 1'b0, 1'b1);
    convert(777, 1'b0, 8, 0, 1'b1, 1'b1);
    rchk(sac_pkg::ADDR_STATUS, 32'h00000008);
    vref_low <= 1'b1;
    convert(100, 1'b0, 8, 0, 1'b0, 1'b0);
    vref_low <= 1'b0;
    ahb(1'b1, sac_pkg::ADDR_CTRL, 32'h00000000);
    host_u.pulse(1);
    rchk(sac_pkg::ADDR_STATUS, 32'h00000008);
    host_u.wake();
    ahb(1'b1, sac_pkg::ADDR_CTRL, 32'h00000001);
    $display("test done: start handling");
    rchk(sac_pkg::ADDR_INT_STATUS, 32'h00000001);
    host_u.pulse(2);
    rchk(sac_pkg::ADDR_STATUS, 32'h00000009);
    rchk(sac_pkg::ADDR_INT_STATUS, 32'h00000002);
    host_u.wake();
    rchk(sac_pkg::ADDR_STATUS, 32'h0000000B);
    repeat (32) @(posedge clk);
    rchk(sac_pkg::ADDR_STATUS, 32'h00000008);
    host_u.pulse(4);
    ahb(1'b0, sac_pkg::ADDR_STATUS, 32'h00000000);
    check(32'h00000002, rd & 32'h00000003);
    rchk(sac_pkg::ADDR_INT_STATUS, 32'h00000006);
    host_u.wake();
    rchk(sac_pkg::ADDR_STATUS, 32'h00000000);
    repeat (SETTLE + 10) @(posedge clk);
    rchk(sac_pkg::ADDR_STATUS, 32'h00000008);
    rchk(sac_pkg::ADDR_INT_STATUS, 32'h00000008);
    convert(4000, 1'b0, 7, 0, 1'b0, 1'b1);
    $display("test done: power modes");
    // let the watcher take the last note before the queue is judged
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : tb_sac_conversion_port
`default_nettype wire
